// *** ffm_defs.svh ***
// ffm_defs.svh: offsets, field positions and reset values of the monitor
// assumes: included by the package and the design files by bare name
`ifndef FFM_DEFS_SVH
`define FFM_DEFS_SVH

// ========================================
// register offsets (4-bit address)
`define FFM_ADDR_W 4
`define FFM_OFS_PRI_FLAGS 4'h1
`define FFM_OFS_SEC_FLAGS 4'h2
`define FFM_OFS_PRI_MASK 4'h3
`define FFM_OFS_SEC_MASK 4'h4
`define FFM_OFS_GLOBAL_CFG 4'h5
`define FFM_OFS_STATUS 4'h6

// ========================================
// primary flag bit positions
`define FFM_PRI_W 8
`define FFM_P_MONLOW 0
`define FFM_P_FUV 1
`define FFM_P_TALM 2
`define FFM_P_SUMMARY 3
`define FFM_P_POR 5
`define FFM_P_CRC 6
`define FFM_P_TSHDN 7

// ========================================
// secondary flag bit positions
`define FFM_SEC_W 8
`define FFM_S_SYSTSHDN 4

// ========================================
// reset values
`define FFM_PRI_RST 8'h20
`define FFM_PRI_MASK_RST 8'h00
`define FFM_SEC_MASK_RST 8'h00
`define FFM_CFG_RST 8'h00
`define FFM_CFG_CLRSEL 0
`define FFM_CFG_ALERTEN 1

`endif

// *** ffm_pkg.sv ***
// ffm_pkg.sv: types of the fault flag monitor
// assumes: ffm_defs.svh beside it
`include "ffm_defs.svh"
package ffm_pkg;

  // ========================================
  // analog detector inputs
  typedef struct packed {
    logic analog_ok;
    logic logic_ok;
    logic monitor_low;
    logic field_uv;
    logic temp_alarm;
    logic temp_shutdown;
    logic temp_system;
  } ffm_detect_t;

  // ========================================
  // serial access events
  typedef struct packed {
    logic cmd_ok;
    logic crc_error;
  } ffm_serial_t;

  // ========================================
  // shutdown controls
  typedef struct packed {
    logic inputs_hiz;
    logic current_ref_off;
    logic regulator_off;
    logic serial_off;
  } ffm_shdn_t;

  typedef enum logic [1:0] {FFM_RUN, FFM_SHDN, FFM_SYSSHDN} ffm_therm_t;

endpackage

// *** ffm_sec_flags.sv ***
// ffm_sec_flags.sv: latched secondary flags and masked summary
// assumes: cleared by a read of the secondary register
`timescale 1ns/10ps
`default_nettype none
`include "ffm_defs.svh"
module ffm_sec_flags (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // causes and control
  input wire logic [`FFM_SEC_W-1:0] set_in,
  input wire logic [`FFM_SEC_W-1:0] mask_in,
  input wire logic rd_clear_in,
  // state
  output logic [`FFM_SEC_W-1:0] flags_out,
  output logic summary_out
);
  import ffm_pkg::*;

  // ========================================
  // per-bit latch, set wins
  genvar i;
  generate
    for (i = 0; i < `FFM_SEC_W; i = i + 1) begin : g_bit
      always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
          flags_out[i] <= 1'b0;
        end else if (set_in[i]) begin
          flags_out[i] <= 1'b1;
        end else if (rd_clear_in) begin
          flags_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ========================================
  // summary of unmasked flags
  assign summary_out = |(flags_out & ~mask_in);
endmodule
`default_nettype wire

// *** ffm_thermal.sv ***
// ffm_thermal.sv: three-level thermal state and shutdown controls
// assumes: detector levels synchronous to mclk_in
`timescale 1ns/10ps
`default_nettype none
`include "ffm_defs.svh"
module ffm_thermal (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // detectors and strap
  input wire logic shdn_in,
  input wire logic sys_in,
  input wire logic ext_supply_in,
  // controls
  output ffm_pkg::ffm_shdn_t shdn_out,
  output ffm_pkg::ffm_therm_t state_out
);
  import ffm_pkg::*;

  ffm_therm_t state_q;
  ffm_therm_t state_d;

  // ========================================
  // next state
  always_comb begin
    case (state_q)
      FFM_RUN: state_d = sys_in ? FFM_SYSSHDN : (shdn_in ? FFM_SHDN : FFM_RUN);
      FFM_SHDN: state_d = sys_in ? FFM_SYSSHDN : (shdn_in ? FFM_SHDN : FFM_RUN);
      FFM_SYSSHDN: state_d = sys_in ? FFM_SYSSHDN :
                             (shdn_in ? FFM_SHDN : FFM_RUN);
      default: state_d = FFM_RUN;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      state_q <= FFM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ========================================
  // registered controls
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      shdn_out <= '0;
    end else begin
      shdn_out.inputs_hiz <= (state_d != FFM_RUN);
      shdn_out.current_ref_off <= (state_d != FFM_RUN);
      shdn_out.regulator_off <= (state_d == FFM_SYSSHDN);
      shdn_out.serial_off <= (state_d == FFM_SYSSHDN) &&
                             !ext_supply_in;
    end
  end

  assign state_out = state_q;
endmodule
`default_nettype wire

// *** ffm_fault_monitor.sv ***
// ffm_fault_monitor.sv: fault flag monitor top
// assumes: serial framing outside gives one-cycle cmd_ok and crc pulses
//
// Overview of operation
// - power good low when both supplies ok
// - monitor comparator never touches power good
// - comparator drives supply_ok_n and monitor flag
// - enabled alert pin low on any unmasked flag
// - mask bits select alert pin sources
// - masks never alter stored primary flags
// - primary flags latch; clear on read
// - summary bit is OR of unmasked secondaries
// - secondary flags clear only on read
// - clear select one: clear on read only
// - select zero: serial command clears, not shutdown
// - 115 degree alarm sets flag, operation continues
// - 150 degree shutdown forces inputs hi-z
// - 165 degree system shutdown, regulator off
// - external supplies keep serial alive
// - internal regulator: retain registers, serial off
// - shutdown disables inputs and current reference
// - chain mode disables serial command clearing
`timescale 1ns/10ps
`default_nettype none
`include "ffm_defs.svh"
module ffm_fault_monitor (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // register port
  input wire logic [`FFM_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // detectors and serial events
  input wire ffm_pkg::ffm_detect_t detect_in,
  input wire logic [`FFM_SEC_W-1:0] sec_cause_in,
  input wire ffm_pkg::ffm_serial_t serial_in,
  // straps
  input wire logic chain_mode_pin_in,
  input wire logic ext_supply_in,
  // pins
  output logic power_good_n_out,
  output logic power_good_n_oe_out,
  output logic supply_ok_n_out,
  output logic supply_ok_n_oe_out,
  output logic alert_pin_n_out,
  output logic alert_pin_n_oe_out,
  // shutdown controls
  output ffm_pkg::ffm_shdn_t shdn_out
);
  import ffm_pkg::*;

  logic [`FFM_PRI_W-1:0] pri_q;
  logic [`FFM_PRI_W-1:0] pri_set;
  logic [`FFM_PRI_W-1:0] pri_view;
  logic [`FFM_PRI_W-1:0] pri_mask_q;
  logic [`FFM_SEC_W-1:0] sec_mask_q;
  logic [7:0] cfg_q;
  logic [`FFM_SEC_W-1:0] sec_flags;
  logic [`FFM_SEC_W-1:0] sec_set;
  logic sec_summary;
  logic rd_pri;
  logic rd_sec;
  logic serial_clr;
  logic alert_d;
  logic alert_q;
  logic pgood_q;
  logic supply_ok_n_q;
  ffm_therm_t therm_state;
  localparam logic [`FFM_PRI_W-1:0] PRI_RST = `FFM_PRI_RST;

  // ========================================
  // access decode
  assign rd_pri = reg_rd_in && (reg_addr_in == `FFM_OFS_PRI_FLAGS);
  assign rd_sec = reg_rd_in && (reg_addr_in == `FFM_OFS_SEC_FLAGS);
  assign serial_clr = serial_in.cmd_ok && !cfg_q[`FFM_CFG_CLRSEL] &&
                      !chain_mode_pin_in;

  // ========================================
  // primary causes
  always_comb begin
    pri_set = '0;
    pri_set[`FFM_P_MONLOW] = detect_in.monitor_low;
    pri_set[`FFM_P_FUV] = detect_in.field_uv;
    pri_set[`FFM_P_TALM] = detect_in.temp_alarm;
    pri_set[`FFM_P_TSHDN] = detect_in.temp_shutdown;
    pri_set[`FFM_P_CRC] = serial_in.crc_error;
  end

  // ========================================
  // primary flag latches
  genvar i;
  generate
    for (i = 0; i < `FFM_PRI_W; i = i + 1) begin : g_pri
      if (i == `FFM_P_SUMMARY) begin : g_sum
        always_ff @(posedge mclk_in) begin
          pri_q[i] <= 1'b0;
        end
      end else begin : g_lat
        always_ff @(posedge mclk_in) begin
          if (!rstn_in) begin
            pri_q[i] <= PRI_RST[i];
          end else if (pri_set[i]) begin
            pri_q[i] <= 1'b1;
          end else if (rd_pri) begin
            pri_q[i] <= 1'b0;
          end else if (serial_clr && (i != `FFM_P_TSHDN)) begin
            pri_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ========================================
  // primary view with live summary
  always_comb begin
    pri_view = pri_q;
    pri_view[`FFM_P_SUMMARY] = sec_summary;
  end

  // ========================================
  // secondary flags
  always_comb begin
    sec_set = sec_cause_in;
    sec_set[`FFM_S_SYSTSHDN] = sec_cause_in[`FFM_S_SYSTSHDN] |
                               detect_in.temp_system;
  end

  ffm_sec_flags u_sec (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .set_in(sec_set),
    .mask_in(sec_mask_q),
    .rd_clear_in(rd_sec),
    .flags_out(sec_flags),
    .summary_out(sec_summary)
  );

  // ========================================
  // thermal protection
  ffm_thermal u_therm (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .shdn_in(detect_in.temp_shutdown),
    .sys_in(detect_in.temp_system),
    .ext_supply_in(ext_supply_in),
    .shdn_out(shdn_out),
    .state_out(therm_state)
  );

  // ========================================
  // writable registers, held through shutdown
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pri_mask_q <= `FFM_PRI_MASK_RST;
      sec_mask_q <= `FFM_SEC_MASK_RST;
      cfg_q <= `FFM_CFG_RST;
    end else if (reg_wr_in && !shdn_out.serial_off) begin
      case (reg_addr_in)
        `FFM_OFS_PRI_MASK: pri_mask_q <= reg_wdata_in;
        `FFM_OFS_SEC_MASK: sec_mask_q <= reg_wdata_in;
        `FFM_OFS_GLOBAL_CFG: cfg_q <= reg_wdata_in;
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // ========================================
  // read data, one cycle later
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FFM_OFS_PRI_FLAGS: reg_rdata_out <= pri_view;
        `FFM_OFS_SEC_FLAGS: reg_rdata_out <= sec_flags;
        `FFM_OFS_PRI_MASK: reg_rdata_out <= pri_mask_q;
        `FFM_OFS_SEC_MASK: reg_rdata_out <= sec_mask_q;
        `FFM_OFS_GLOBAL_CFG: reg_rdata_out <= cfg_q;
        `FFM_OFS_STATUS: reg_rdata_out <= {6'h00, therm_state};
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ========================================
  // alert pin
  assign alert_d = cfg_q[`FFM_CFG_ALERTEN] &&
                   (|(pri_view & ~pri_mask_q));

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= alert_d;
    end
  end

  assign alert_pin_n_out = 1'b0;
  assign alert_pin_n_oe_out = alert_q;

  // ========================================
  // power good and supply ok pins
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pgood_q <= 1'b0;
      supply_ok_n_q <= 1'b0;
    end else begin
      pgood_q <= detect_in.analog_ok && detect_in.logic_ok;
      supply_ok_n_q <= !detect_in.monitor_low;
    end
  end

  // power good: high-side open drain, pulls high when not ready
  assign power_good_n_out = 1'b1;
  assign power_good_n_oe_out = !pgood_q;
  assign supply_ok_n_out = 1'b0;
  assign supply_ok_n_oe_out = supply_ok_n_q;
endmodule
`default_nettype wire

// *** ffm_host_model.sv ***
// ffm_host_model.sv: host side serial events and resolved pin levels
// assumes: bench raises the event requests, pins carry pull resistors
`timescale 1ns/10ps
`default_nettype none
module ffm_host_model (
  // requests from the bench
  input wire logic cmd_req_in,
  input wire logic crc_req_in,
  // pins of the monitor
  input wire logic pg_in,
  input wire logic pg_oe_in,
  input wire logic ok_in,
  input wire logic ok_oe_in,
  input wire logic al_in,
  input wire logic al_oe_in,
  // serial events and wire levels
  output ffm_pkg::ffm_serial_t serial_out,
  output logic pg_wire_out,
  output logic ok_wire_out,
  output logic al_wire_out
);
  import ffm_pkg::*;
  // ========================================
  // one-cycle serial events
  assign serial_out = {cmd_req_in, crc_req_in};
  // ========================================
  // pulldown on power good, pullups elsewhere
  assign pg_wire_out = pg_oe_in ? pg_in : 1'b0;
  assign ok_wire_out = ok_oe_in ? ok_in : 1'b1;
  assign al_wire_out = al_oe_in ? al_in : 1'b1;
endmodule
`default_nettype wire

// *** ffm_fault_monitor_checker.sv ***
// ffm_fault_monitor_checker.sv: port assertions of the monitor
// assumes: bound to the monitor top from the testbench
`timescale 1ns/10ps
`default_nettype none
`include "ffm_defs.svh"
module ffm_fault_monitor_checker (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // watched ports
  input wire logic [`FFM_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire ffm_pkg::ffm_detect_t detect_in,
  input wire logic ext_supply_in,
  input wire logic power_good_n_oe_out,
  input wire logic supply_ok_n_oe_out,
  input wire ffm_pkg::ffm_shdn_t shdn_out
);
  import ffm_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  wire logic sup_ok = detect_in.analog_ok & detect_in.logic_ok;
  wire logic pri_rd = reg_rd_in && reg_addr_in == `FFM_OFS_PRI_FLAGS;
  wire logic sys = detect_in.temp_system;
  // ========================================
  // assertions
  property p_pg_off; !sup_ok |=> power_good_n_oe_out; endproperty
  a_pg_off: assert property (p_pg_off) else $error("pg not off");
  property p_pg_on;
    sup_ok && detect_in.monitor_low |=> !power_good_n_oe_out;
  endproperty
  a_pg_on: assert property (p_pg_on) else $error("pg not on");
  property p_mon;
    1'b1 |=> supply_ok_n_oe_out == !$past(detect_in.monitor_low);
  endproperty
  a_mon: assert property (p_mon) else $error("supply ok wrong");
  property p_latch;
    pri_rd && $past(rstn_in) && $past(detect_in.field_uv)
      |=> reg_rdata_out[`FFM_P_FUV];
  endproperty
  a_latch: assert property (p_latch) else $error("flag lost");
  property p_shdn;
    detect_in.temp_shutdown |=> shdn_out.inputs_hiz && shdn_out.current_ref_off;
  endproperty
  a_shdn: assert property (p_shdn) else $error("no shutdown");
  property p_sys;
    sys |=> shdn_out.regulator_off && shdn_out.inputs_hiz;
  endproperty
  a_sys: assert property (p_sys) else $error("no sys shutdown");
  property p_ext; sys && ext_supply_in |=> !shdn_out.serial_off; endproperty
  a_ext: assert property (p_ext) else $error("serial lost");
  property p_int; sys && !ext_supply_in |=> shdn_out.serial_off; endproperty
  a_int: assert property (p_int) else $error("serial kept");
endmodule
`default_nettype wire

// *** ffm_fault_monitor_tb.sv ***
// ffm_fault_monitor_tb.sv: self-checking bench of the monitor
// assumes: design, checker and host model compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "ffm_defs.svh"
module ffm_fault_monitor_tb;
  import ffm_pkg::*;
  localparam logic [3:0] o_pri = `FFM_OFS_PRI_FLAGS;
  localparam logic [3:0] o_sec = `FFM_OFS_SEC_FLAGS;
  localparam logic [3:0] o_pm = `FFM_OFS_PRI_MASK;
  localparam logic [3:0] o_sm = `FFM_OFS_SEC_MASK;
  localparam logic [3:0] o_cfg = `FFM_OFS_GLOBAL_CFG;
  logic mclk_in, rstn_in, wr, rd, cmd, crc, chain, ext;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, sec;
  logic pg_oe, ok_oe, al_oe, pg_o, ok_o, al_o, pg_w, ok_w, al_w;
  ffm_detect_t det;
  ffm_serial_t ser;
  ffm_shdn_t shdn;
  int error_cnt = 0;
  int cmp_count = 0;
  // ========================================
  // design and host
  ffm_fault_monitor DUT (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .detect_in(det),
    .sec_cause_in(sec), .serial_in(ser), .chain_mode_pin_in(chain),
    .ext_supply_in(ext), .power_good_n_out(pg_o),
    .power_good_n_oe_out(pg_oe), .supply_ok_n_out(ok_o),
    .supply_ok_n_oe_out(ok_oe), .alert_pin_n_out(al_o),
    .alert_pin_n_oe_out(al_oe), .shdn_out(shdn));
  ffm_host_model u_host (.cmd_req_in(cmd), .crc_req_in(crc), .pg_in(pg_o),
    .pg_oe_in(pg_oe), .ok_in(ok_o), .ok_oe_in(ok_oe), .al_in(al_o),
    .al_oe_in(al_oe), .serial_out(ser), .pg_wire_out(pg_w),
    .ok_wire_out(ok_w), .al_wire_out(al_w));
  // ========================================
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic ev(input logic c, input logic e);
    @(posedge mclk_in);
    cmd <= c;
    crc <= e;
    @(posedge mclk_in);
    cmd <= 1'b0;
    crc <= 1'b0;
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ========================================
  // clock and watchdog
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (3000) @(posedge mclk_in);
    error_cnt++;
    end_sim();
  end
  // ========================================
  // tests
  initial begin
    {rstn_in, wr, rd, cmd, crc, chain, ext} = 7'h00;
    addr = 4'h0;
    wdata = 8'h00;
    sec = 8'h00;
    det = 7'h60;
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd_reg(o_pri, 8'h20);
    rd_reg(o_pri, 8'h00);
    det.analog_ok <= 1'b0;
    step(2);
    check({7'h00, pg_w}, 8'h01);
    det.analog_ok <= 1'b1;
    det.monitor_low <= 1'b1;
    step(2);
    check({6'h00, pg_w, ok_w}, 8'h01);
    rd_reg(o_pri, 8'h01);
    det.monitor_low <= 1'b0;
    step(2);
    check({7'h00, ok_w}, 8'h00);
    rd_reg(o_pri, 8'h01);
    det.field_uv <= 1'b1;
    rd_reg(o_pri, 8'h02);
    det.field_uv <= 1'b0;
    rd_reg(o_pri, 8'h02);
    $display("test pins done");
    wr_reg(o_cfg, 8'h02);
    check({7'h00, al_w}, 8'h01);
    ev(1'b0, 1'b1);
    step(2);
    check({7'h00, al_w}, 8'h00);
    wr_reg(o_pm, 8'h40);
    step(1);
    check({7'h00, al_w}, 8'h01);
    rd_reg(o_pri, 8'h40);
    wr_reg(o_pm, 8'h00);
    det.temp_alarm <= 1'b1;
    step(2);
    det.temp_alarm <= 1'b0;
    check({4'h0, shdn}, 8'h00);
    rd_reg(o_pri, 8'h04);
    $display("test alert done");
    det.temp_shutdown <= 1'b1;
    step(2);
    check({4'h0, shdn}, 8'h0C);
    det.temp_shutdown <= 1'b0;
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b0);
    rd_reg(o_pri, 8'h80);
    wr_reg(o_cfg, 8'h03);
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b0);
    rd_reg(o_pri, 8'h40);
    wr_reg(o_cfg, 8'h02);
    chain <= 1'b1;
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b0);
    rd_reg(o_pri, 8'h40);
    chain <= 1'b0;
    $display("test clear done");
    sec <= 8'h01;
    rd_reg(o_pri, 8'h08);
    rd_reg(o_sec, 8'h01);
    rd_reg(o_sec, 8'h01);
    sec <= 8'h00;
    wr_reg(o_sm, 8'h01);
    rd_reg(o_pri, 8'h00);
    wr_reg(o_sm, 8'h00);
    rd_reg(o_pri, 8'h08);
    rd_reg(o_sec, 8'h01);
    rd_reg(o_sec, 8'h00);
    $display("test secondary done");
    ext <= 1'b1;
    det.temp_system <= 1'b1;
    step(2);
    check({4'h0, shdn}, 8'h0E);
    wr_reg(o_pm, 8'h01);
    rd_reg(o_pm, 8'h01);
    ext <= 1'b0;
    step(2);
    check({4'h0, shdn}, 8'h0F);
    wr_reg(o_pm, 8'h00);
    rd_reg(o_pm, 8'h01);
    rd_reg(o_sec, 8'h10);
    $display("test thermal done");
    end_sim();
  end
endmodule
bind ffm_fault_monitor ffm_fault_monitor_checker u_chk (.mclk_in(mclk_in),
  .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .detect_in(detect_in),
  .ext_supply_in(ext_supply_in), .power_good_n_oe_out(power_good_n_oe_out),
  .supply_ok_n_oe_out(supply_ok_n_oe_out), .shdn_out(shdn_out));
`default_nettype wire
